// file: design/hio_cmd.sv
`timescale 1ns/1ns
`default_nettype none
module hio_cmd (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 in_valid,
  input  wire logic [15:0]          in_data,
  output logic                      in_ready,
  output logic                      out_valid,
  output logic      [15:0]          out_data,
  input  wire logic                 out_ready,
  input  wire hio_pkg::hio_mode_t   mode,
  input  wire logic                 write_protect,
  input  wire logic                 scan_we,
  input  wire logic [7:0]           scan_addr,
  input  wire logic [15:0]          scan_data,
  output hio_pkg::hio_bit_wr_t      phys_wr,
  output hio_pkg::hio_blk_t         blk,
  input  wire logic                 blk_ack,
  input  wire logic [15:0]          blk_rdata
);
  hio_pkg::hio_state_t  state;
  hio_pkg::hio_state_t  next_state;
  hio_pkg::hio_cmd_t    op;
  hio_pkg::hio_cmd_t    next_op;
  logic [15:0]          rem;
  logic [15:0]          next_rem;
  logic [15:0]          n;
  logic [15:0]          next_n;
  logic [15:0]          left;
  logic [15:0]          next_left;
  logic [15:0]          cur;
  logic [15:0]          next_cur;
  logic [15:0]          dword;
  logic [15:0]          next_dword;
  logic [3:0]           bitx;
  logic [3:0]           next_bitx;
  logic [15:0]          sgnl;
  logic [15:0]          next_sgnl;
  logic [15:0]          rlen;
  logic [15:0]          next_rlen;
  logic                 err;
  logic                 next_err;
  logic                 next_out_valid;
  logic [15:0]          next_out_data;
  hio_pkg::hio_bit_wr_t next_phys_wr;
  hio_pkg::hio_blk_t    next_blk;
  logic                 rw_en;
  logic                 next_rw_en;
  logic [11:0]          rw_idx;
  logic [11:0]          next_rw_idx;
  logic [15:0]          rw_data;
  logic [15:0]          next_rw_data;
  logic [15:0]          io_rd;
  logic [15:0]          reg_rd;
  logic                 take;
  logic                 emit_done;
  logic [15:0]          pn;
  logic [15:0]          ps;
  logic                 refuse;
  logic                 range_bad;
  hio_pkg::hio_state_t  item_state;

  hio_io_table u_io (
    .core_clk  (core_clk),
    .scan_we   (scan_we),
    .scan_addr (scan_addr),
    .scan_data (scan_data),
    .bit_wr    (phys_wr),
    .rd_addr   (cur[11:0]),
    .rd_data   (io_rd)
  );

  hio_reg_file u_reg (
    .core_clk (core_clk),
    .we       (rw_en),
    .wr_idx   (rw_idx),
    .wr_data  (rw_data),
    .rd_idx   (cur[11:0]),
    .rd_data  (reg_rd)
  );

  // leftover words are drained before a write or error answer and after a read answer, header goes last for writes
  function automatic hio_pkg::hio_state_t fin_of(input logic [15:0] r, input logic hdr_sent);
    if (r != 16'h0000) begin
      fin_of = hio_pkg::S_DRAIN;
    end else if (hdr_sent) begin
      fin_op_sel: fin_of = hio_pkg::S_OP;
    end else begin
      fin_of = hio_pkg::S_HDR;
    end
  endfunction : fin_of

  always_comb begin
    case (state)
      hio_pkg::S_OP, hio_pkg::S_LEN, hio_pkg::S_N, hio_pkg::S_SA,
      hio_pkg::S_ADDR, hio_pkg::S_DATA: in_ready = 1'b1;
      hio_pkg::S_DRAIN:                 in_ready = (rem != 16'h0000);
      default:                          in_ready = 1'b0;
    endcase
  end

  assign take      = in_valid && in_ready;
  assign emit_done = out_valid && out_ready;

  always_comb begin
    next_state     = state;
    next_op        = op;
    next_rem       = rem;
    next_n         = n;
    next_left      = left;
    next_cur       = cur;
    next_dword     = dword;
    next_bitx      = bitx;
    next_sgnl      = sgnl;
    next_rlen      = rlen;
    next_err       = err;
    next_out_valid = out_valid;
    next_out_data  = out_data;
    next_phys_wr   = '0;
    next_blk       = blk;
    next_rw_en     = 1'b0;
    next_rw_idx    = rw_idx;
    next_rw_data   = rw_data;
    pn             = (state == hio_pkg::S_N) ? in_data : n;
    ps             = in_data;
    item_state     = op.scat ? hio_pkg::S_ADDR : (op.blk ? hio_pkg::S_BLK : hio_pkg::S_EMIT);
    refuse = (!op.rd && write_protect)
          || (op.blk && op.rd && mode != hio_pkg::MODE_RUN_PROGRAM
              && mode != hio_pkg::MODE_DISABLE)
          || (op.blk && !op.rd && mode != hio_pkg::MODE_RUN_PROGRAM);
    range_bad = (pn == 16'h0000)
             || (op.blk && pn > hio_pkg::N_MAX_BLK)
             || (op.rg && op.rd && !op.scat && pn > hio_pkg::N_MAX_REG)
             || (op.rg && !op.scat && ps < hio_pkg::REG_BASE && state == hio_pkg::S_SA);
    case (state)
      hio_pkg::S_OP: begin
        next_err  = 1'b0;
        next_bitx = 4'h0;
        if (take) begin
          next_op    = hio_pkg::hio_decode(in_data[7:0]);
          next_state = hio_pkg::S_LEN;
        end
      end
      hio_pkg::S_LEN: begin
        if (take) begin
          next_rem = in_data >> 1;
          if (op.known) begin
            next_state = hio_pkg::S_N;
          end else begin
            next_err   = 1'b1;
            next_state = hio_pkg::S_DRAIN;
          end
        end
      end
      hio_pkg::S_N, hio_pkg::S_SA: begin
        if (take) begin
          next_rem = rem - 16'h0001;
          if (state == hio_pkg::S_N) begin
            next_n = in_data;
          end else begin
            next_cur = in_data;
          end
          if (state == hio_pkg::S_SA || op.scat) begin
            next_left = (op.io && !op.rd && !op.scat && op.w16) ? (pn << 4) : pn;
            next_sgnl = (pn + 16'h000f) >> 4;
            next_rlen = op.rd ? ((pn << 1) + (op.sgn ? (next_sgnl << 1) : 16'h0000))
                              : 16'h0000;
            if (refuse || range_bad) begin
              next_err   = 1'b1;
              next_state = hio_pkg::S_DRAIN;
            end else if (op.rd) begin
              next_state = hio_pkg::S_HDR;
            end else begin
              next_state = op.scat ? hio_pkg::S_ADDR : hio_pkg::S_DATA;
            end
          end else begin
            next_state = hio_pkg::S_SA;
          end
        end
      end
      hio_pkg::S_HDR: begin
        if (!out_valid) begin
          next_out_valid = 1'b1;
          next_out_data  = {8'h00, err ? hio_pkg::OP_ERR : hio_pkg::OP_ACK};
        end else if (emit_done) begin
          next_out_valid = 1'b0;
          next_state     = hio_pkg::S_RLEN;
        end
      end
      hio_pkg::S_RLEN: begin
        if (!out_valid) begin
          next_out_valid = 1'b1;
          next_out_data  = err ? 16'h0000 : rlen;
        end else if (emit_done) begin
          next_out_valid = 1'b0;
          next_state     = (op.rd && !err) ? item_state : hio_pkg::S_OP;
          next_blk       = '{req: op.blk && op.rd && !err, we: 1'b0, addr: cur, wdata: dword};
        end
      end
      hio_pkg::S_ADDR: begin
        if (take) begin
          next_rem   = rem - 16'h0001;
          next_cur   = in_data;
          next_state = op.rd ? hio_pkg::S_EMIT : hio_pkg::S_DATA;
        end
      end
      hio_pkg::S_DATA: begin
        if (take) begin
          next_rem   = rem - 16'h0001;
          next_dword = in_data;
          if (op.io) begin
            next_state = hio_pkg::S_BITS;
          end else if (op.rg) begin
            next_rw_en   = 1'b1;
            next_rw_idx  = cur[11:0];
            next_rw_data = in_data;
            next_left    = left - 16'h0001;
            next_cur     = cur + 16'h0001;
            if (left == 16'h0001) begin
              next_state = fin_of(next_rem, 1'b0);
            end else begin
              next_state = op.scat ? hio_pkg::S_ADDR : hio_pkg::S_DATA;
            end
          end else begin
            next_blk   = '{req: 1'b1, we: 1'b1, addr: cur, wdata: in_data};
            next_state = hio_pkg::S_BLK;
          end
        end
      end
      hio_pkg::S_BITS: begin
        next_phys_wr = '{en: 1'b1, addr: cur[11:0], val: dword[bitx]};
        next_left    = left - 16'h0001;
        next_cur     = cur + 16'h0001;
        next_bitx    = op.scat ? 4'h0 : bitx + 4'h1;
        if (left == 16'h0001) begin
          next_state = fin_of(rem, 1'b0);
        end else if (op.scat) begin
          next_state = hio_pkg::S_ADDR;
        end else if (bitx == 4'hf) begin
          next_state = hio_pkg::S_DATA;
        end
      end
      hio_pkg::S_BLK: begin
        if (blk_ack) begin
          next_blk.req = 1'b0;
          if (op.rd) begin
            next_dword = blk_rdata;
            next_state = hio_pkg::S_EMIT;
          end else begin
            next_left  = left - 16'h0001;
            next_cur   = cur + 16'h0001;
            next_state = (left == 16'h0001) ? fin_of(rem, 1'b0) : hio_pkg::S_DATA;
          end
        end
      end
      hio_pkg::S_EMIT: begin
        if (!out_valid) begin
          next_out_valid = 1'b1;
          next_out_data  = op.blk ? dword : (op.io ? io_rd : reg_rd);
        end else if (emit_done) begin
          next_out_valid = 1'b0;
          next_left      = left - 16'h0001;
          next_cur       = cur + (op.io ? 16'h0010 : 16'h0001);
          if (left == 16'h0001) begin
            next_state = op.sgn ? hio_pkg::S_SIGN : fin_of(rem, 1'b1);
          end else begin
            next_state = item_state;
            next_blk   = '{req: op.blk, we: 1'b0, addr: next_cur, wdata: dword};
          end
        end
      end
      hio_pkg::S_SIGN: begin
        if (!out_valid) begin
          next_out_valid = 1'b1;
          next_out_data  = 16'h0000;
        end else if (emit_done) begin
          next_out_valid = 1'b0;
          next_sgnl      = sgnl - 16'h0001;
          if (sgnl == 16'h0001) begin
            next_state = fin_of(rem, 1'b1);
          end
        end
      end
      hio_pkg::S_DRAIN: begin
        // sign words of signed writes and refused bodies are consumed unused
        if (take) begin
          next_rem = rem - 16'h0001;
        end else if (rem == 16'h0000) begin
          next_state = fin_of(16'h0000, op.rd && !err);
        end
      end
      default: begin
        next_state = hio_pkg::S_OP;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state     <= hio_pkg::S_OP;
      op        <= '0;
      rem       <= 16'h0000;
      n         <= 16'h0000;
      left      <= 16'h0000;
      cur       <= 16'h0000;
      dword     <= 16'h0000;
      bitx      <= 4'h0;
      sgnl      <= 16'h0000;
      rlen      <= 16'h0000;
      err       <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      phys_wr   <= '0;
      blk       <= '0;
      rw_en     <= 1'b0;
      rw_idx    <= 12'h000;
      rw_data   <= 16'h0000;
    end else begin
      state     <= next_state;
      op        <= next_op;
      rem       <= next_rem;
      n         <= next_n;
      left      <= next_left;
      cur       <= next_cur;
      dword     <= next_dword;
      bitx      <= next_bitx;
      sgnl      <= next_sgnl;
      rlen      <= next_rlen;
      err       <= next_err;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
      phys_wr   <= next_phys_wr;
      blk       <= next_blk;
      rw_en     <= next_rw_en;
      rw_idx    <= next_rw_idx;
      rw_data   <= next_rw_data;
    end
  end
endmodule : hio_cmd
`default_nettype wire

// file: design/hio_pkg.sv
// Behaviour
// - contiguous 16-bit group read returns input OR output status per bit
// - read data right-aligned; bit zero of first word is starting address
// - successful write answered by bare acknowledgement, no status data
// - individual-output write updates status table and physical outputs per bit
// - 16N output write updates N consecutive 16-bit blocks and outputs
// - scattered output write uses only bit zero of each data word
// - output, register and push writes need write protect disabled
// - scattered group read reaches input, output and control relay areas
// - signed-register variants accepted although registers are 16 bits
// - signed-register read returns all sign bits as zero
// - signed-register write ignores the sign field, stores 16-bit values
// - sign words follow register data, bit zero for first register
// - register read opcode 4, count 1 to 256, start at least 4096
// - register write data spans full 0 to 65535
// - pull reads 1 to 128 words ascending, run/program or disable only
// - pull answer opcode 0, variable length, data in ascending order
// - push writes N words ascending, run/program mode only
package hio_pkg;

  localparam logic [7:0]  OP_ACK         = 8'h00;
  localparam logic [7:0]  OP_ERR         = 8'h0f;
  localparam logic [7:0]  OP_RD_16N      = 8'h01;
  localparam logic [7:0]  OP_RD_16N_SCAT = 8'h02;
  localparam logic [7:0]  OP_WR_N_OUT    = 8'h03;
  localparam logic [7:0]  OP_RD_REG      = 8'h04;
  localparam logic [7:0]  OP_WR_16N_OUT  = 8'h05;
  localparam logic [7:0]  OP_RD_SREG     = 8'h06;
  localparam logic [7:0]  OP_WR_SCAT_OUT = 8'h07;
  localparam logic [7:0]  OP_RD_SCAT_REG = 8'h08;
  localparam logic [7:0]  OP_WR_REG      = 8'h09;
  localparam logic [7:0]  OP_WR_SREG     = 8'h0a;
  localparam logic [7:0]  OP_WR_SCAT_REG = 8'h0b;
  localparam logic [7:0]  OP_PULL        = 8'h1c;
  localparam logic [7:0]  OP_PUSH        = 8'h1d;
  localparam logic [15:0] REG_BASE       = 16'h1000;
  localparam logic [15:0] N_MAX_REG      = 16'h0100;
  localparam logic [15:0] N_MAX_BLK      = 16'h0080;
  localparam int          IO_WORDS       = 256;
  localparam int          REG_WORDS      = 4096;

  typedef enum logic [1:0] {
    MODE_PROGRAM     = 2'h0,
    MODE_RUN_PROGRAM = 2'h1,
    MODE_RUN         = 2'h2,
    MODE_DISABLE     = 2'h3
  } hio_mode_t;

  typedef enum logic [3:0] {
    S_OP    = 4'h0,
    S_LEN   = 4'h1,
    S_N     = 4'h3,
    S_SA    = 4'h2,
    S_HDR   = 4'h6,
    S_RLEN  = 4'h7,
    S_ADDR  = 4'h5,
    S_DATA  = 4'h4,
    S_BITS  = 4'hc,
    S_BLK   = 4'hd,
    S_EMIT  = 4'hf,
    S_SIGN  = 4'he,
    S_DRAIN = 4'ha
  } hio_state_t;

  typedef struct packed {
    logic rd;
    logic io;
    logic rg;
    logic blk;
    logic scat;
    logic w16;
    logic sgn;
    logic known;
  } hio_cmd_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic        val;
  } hio_bit_wr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hio_blk_t;

  function automatic hio_cmd_t hio_decode(input logic [7:0] op);
    case (op)
      OP_RD_16N:      hio_decode = 8'b1100_0001;
      OP_RD_16N_SCAT: hio_decode = 8'b1100_1001;
      OP_WR_N_OUT:    hio_decode = 8'b0100_0001;
      OP_WR_16N_OUT:  hio_decode = 8'b0100_0101;
      OP_WR_SCAT_OUT: hio_decode = 8'b0100_1001;
      OP_RD_REG:      hio_decode = 8'b1010_0001;
      OP_RD_SREG:     hio_decode = 8'b1010_0011;
      OP_RD_SCAT_REG: hio_decode = 8'b1010_1001;
      OP_WR_REG:      hio_decode = 8'b0010_0001;
      OP_WR_SREG:     hio_decode = 8'b0010_0011;
      OP_WR_SCAT_REG: hio_decode = 8'b0010_1001;
      OP_PULL:        hio_decode = 8'b1001_0001;
      OP_PUSH:        hio_decode = 8'b0001_0001;
      default:        hio_decode = 8'b0000_0000;
    endcase
  endfunction : hio_decode

endpackage : hio_pkg

// file: design/hio_io_table.sv
`timescale 1ns/1ns
`default_nettype none
module hio_io_table #(
  parameter int WORDS = hio_pkg::IO_WORDS
) (
  input  wire logic               core_clk,
  input  wire logic               scan_we,
  input  wire logic [7:0]         scan_addr,
  input  wire logic [15:0]        scan_data,
  input  wire hio_pkg::hio_bit_wr_t bit_wr,
  input  wire logic [11:0]        rd_addr,
  output logic      [15:0]        rd_data
);
  logic [15:0] in_tab  [WORDS];
  logic [15:0] out_tab [WORDS];
  logic [7:0]  w0;
  logic [7:0]  w1;
  logic [31:0] pair;

  // control relay area shares the same bit space, so one table covers all
  function automatic logic [15:0] or_word(input logic [7:0] w);
    or_word = in_tab[w] | out_tab[w];
  endfunction : or_word

  always_comb begin
    w0      = rd_addr[11:4];
    w1      = w0 + 8'h01;
    pair    = {or_word(w1), or_word(w0)} >> rd_addr[3:0];
    rd_data = pair[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (scan_we) begin
      in_tab[scan_addr] <= scan_data;
    end
    if (bit_wr.en) begin
      out_tab[bit_wr.addr[11:4]][bit_wr.addr[3:0]] <= bit_wr.val;
    end
  end
endmodule : hio_io_table
`default_nettype wire

// file: design/hio_reg_file.sv
`timescale 1ns/1ns
`default_nettype none
module hio_reg_file #(
  parameter int WORDS = hio_pkg::REG_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        we,
  input  wire logic [11:0] wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [11:0] rd_idx,
  output logic      [15:0] rd_data
);
  logic [15:0] mem [WORDS];

  assign rd_data = mem[rd_idx];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[wr_idx] <= wr_data;
    end
  end
endmodule : hio_reg_file
`default_nettype wire

// file: testbench/hio_chk.sv
`timescale 1ns/1ns
`default_nettype none
module hio_chk (
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire logic                 in_valid,
  input wire logic [15:0]          in_data,
  input wire logic                 in_ready,
  input wire logic                 out_valid,
  input wire logic [15:0]          out_data,
  input wire logic                 out_ready,
  input wire hio_pkg::hio_mode_t   mode,
  input wire logic                 write_protect,
  input wire logic                 scan_we,
  input wire logic [7:0]           scan_addr,
  input wire logic [15:0]          scan_data,
  input wire hio_pkg::hio_bit_wr_t phys_wr,
  input wire hio_pkg::hio_blk_t    blk,
  input wire logic                 blk_ack,
  input wire logic [15:0]          blk_rdata
);
  logic [15:0] cap;
  always_ff @(posedge core_clk) begin
    if (blk.req && blk_ack) cap <= blk_rdata;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_word_done; out_valid && out_ready; endsequence
  sequence s_blk_wait; blk.req && !blk_ack; endsequence
  sequence s_pull_done; blk.req && blk_ack && !blk.we; endsequence
  a_reset_idle: assert property (disable iff (1'b0) srst |=> !out_valid && !blk.req && !phys_wr.en)
    else $error("not idle after reset");
  a_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("answer word dropped early");
  a_word_gap: assert property (s_word_done |=> !out_valid)
    else $error("answer word not released");
  a_quiet_in: assert property (out_valid |-> !in_ready)
    else $error("command taken while answering");
  a_write_first: assert property (phys_wr.en |-> !out_valid)
    else $error("acknowledge before write finished");
  a_blk_hold: assert property (s_blk_wait |=> blk.req && $stable(blk.addr) && $stable(blk.wdata))
    else $error("block request changed while waiting");
  a_wp_guard: assert property (write_protect && $past(write_protect) |-> !phys_wr.en && !(blk.req && blk.we))
    else $error("write while protected");
  a_push_mode: assert property (blk.req && blk.we |-> mode == hio_pkg::MODE_RUN_PROGRAM)
    else $error("push outside run/program");
  a_pull_mode: assert property (blk.req && !blk.we |-> mode inside {hio_pkg::MODE_RUN_PROGRAM, hio_pkg::MODE_DISABLE})
    else $error("pull in wrong mode");
  a_pull_pass: assert property (s_pull_done |-> ##[1:3] (out_valid && out_data == cap))
    else $error("pulled word not forwarded");
endmodule : hio_chk
bind hio_cmd hio_chk i_chk (.core_clk(core_clk), .srst(srst), .in_valid(in_valid),
  .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
  .out_ready(out_ready), .mode(mode), .write_protect(write_protect), .scan_we(scan_we),
  .scan_addr(scan_addr), .scan_data(scan_data), .phys_wr(phys_wr), .blk(blk),
  .blk_ack(blk_ack), .blk_rdata(blk_rdata));
`default_nettype wire

// file: testbench/hio_blk_model.sv
`timescale 1ns/1ns
`default_nettype none
module hio_blk_model (
  input  wire logic              core_clk,
  input  wire logic              slow,
  input  wire hio_pkg::hio_blk_t blk,
  output logic                   blk_ack,
  output logic [15:0]            blk_rdata,
  output int                     wr_count
);
  logic [15:0] mem [0:63];
  int          wait_n;
  initial begin
    blk_ack = 1'b0;
    blk_rdata = 16'h0;
    wr_count = 0;
    wait_n = 0;
  end
  // idle bus toggles so a stale word is never mistaken for data
  always @(posedge core_clk) begin
    blk_ack <= 1'b0;
    blk_rdata <= ~blk_rdata;
    if (blk.req && !blk_ack) begin
      if (wait_n < (slow ? 5 : 1)) wait_n <= wait_n + 1;
      else begin
        wait_n <= 0;
        blk_ack <= 1'b1;
        if (blk.we) begin
          mem[blk.addr[5:0]] <= blk.wdata;
          wr_count <= wr_count + 1;
        end else blk_rdata <= blk.addr ^ 16'ha5c3;
      end
    end
  end
endmodule : hio_blk_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {
    logic [7:0] op; int nb; logic [0:3][15:0] b; logic wp; logic [1:0] md;
    logic [7:0] eop; logic [15:0] elen; logic [15:0] ed0; logic [15:0] el;
  } hio_row_t;
  logic core_clk = 1'b0, srst = 1'b1, in_valid = 1'b0, out_ready = 1'b0, slow = 1'b0;
  logic write_protect = 1'b0, scan_we = 1'b0, out_valid, in_ready, blk_ack;
  logic [15:0] in_data = 16'h0, out_data, scan_data = 16'h0, blk_rdata, rop, rlen, x;
  logic [7:0] scan_addr = 8'h0;
  hio_pkg::hio_mode_t mode = hio_pkg::MODE_RUN_PROGRAM;
  hio_pkg::hio_bit_wr_t phys_wr;
  hio_pkg::hio_blk_t blk;
  logic io_out [0:4095];
  logic [15:0] rq [$];
  int bad_count = 0, num_checks = 0, pulse_n = 0, stall = 0, wr_count;
  hio_row_t rows [28] = '{
    '{8'h05,3,'{16'h1,16'h20,16'h0,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h03,3,'{16'h4,16'h22,16'ha,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h01,2,'{16'h1,16'h20,16'h0,16'h0},0,1,8'h0,16'h2,16'hf8,16'hf8},
    '{8'h03,3,'{16'h4,16'h20,16'hffff,16'h0},1,1,8'hf,16'h0,16'h0,16'h0},
    '{8'h01,2,'{16'h1,16'h20,16'h0,16'h0},0,1,8'h0,16'h2,16'hf8,16'hf8},
    '{8'h07,3,'{16'h1,16'h28,16'hfffe,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h07,3,'{16'h1,16'h29,16'h3,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h02,2,'{16'h1,16'h20,16'h0,16'h0},0,1,8'h0,16'h2,16'h2f8,16'h2f8},
    '{8'h05,3,'{16'h1,16'h40,16'h8001,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h01,2,'{16'h1,16'h40,16'h0,16'h0},0,1,8'h0,16'h2,16'h8001,16'h8001},
    '{8'h09,3,'{16'h1,16'h1000,16'hffff,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h09,3,'{16'h1,16'h1000,16'h0,16'h0},1,1,8'hf,16'h0,16'h0,16'h0},
    '{8'h0a,4,'{16'h1,16'h1001,16'h1234,16'h1},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h06,2,'{16'h2,16'h1000,16'h0,16'h0},0,1,8'h0,16'h6,16'hffff,16'h0},
    '{8'h04,2,'{16'h2,16'h1000,16'h0,16'h0},0,1,8'h0,16'h4,16'hffff,16'h1234},
    '{8'h08,2,'{16'h1,16'h1001,16'h0,16'h0},0,1,8'h0,16'h2,16'h1234,16'h1234},
    '{8'h04,2,'{16'h1,16'h0fff,16'h0,16'h0},0,1,8'hf,16'h0,16'h0,16'h0},
    '{8'h04,2,'{16'h101,16'h1000,16'h0,16'h0},0,1,8'hf,16'h0,16'h0,16'h0},
    '{8'h1c,2,'{16'h2,16'ha,16'h0,16'h0},0,1,8'h0,16'h4,16'ha5c9,16'ha5c8},
    '{8'h1c,2,'{16'h1,16'h0,16'h0,16'h0},0,2,8'hf,16'h0,16'h0,16'h0},
    '{8'h1c,2,'{16'h81,16'h0,16'h0,16'h0},0,3,8'hf,16'h0,16'h0,16'h0},
    '{8'h1c,2,'{16'h1,16'h0,16'h0,16'h0},0,3,8'h0,16'h2,16'ha5c3,16'ha5c3},
    '{8'h1d,4,'{16'h2,16'h14,16'h1111,16'h2222},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h1d,3,'{16'h1,16'h14,16'h5555,16'h0},0,3,8'hf,16'h0,16'h0,16'h0},
    '{8'h1d,3,'{16'h1,16'h14,16'h5555,16'h0},1,1,8'hf,16'h0,16'h0,16'h0},
    '{8'h0b,3,'{16'h1,16'h1002,16'hbeef,16'h0},0,1,8'h0,16'h0,16'h0,16'h0},
    '{8'h08,2,'{16'h1,16'h1002,16'h0,16'h0},0,1,8'h0,16'h2,16'hbeef,16'hbeef},
    '{8'h33,2,'{16'h1,16'h0,16'h0,16'h0},0,1,8'hf,16'h0,16'h0,16'h0}};

  hio_cmd i_dut (.core_clk(core_clk), .srst(srst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .mode(mode), .write_protect(write_protect), .scan_we(scan_we), .scan_addr(scan_addr),
    .scan_data(scan_data), .phys_wr(phys_wr), .blk(blk), .blk_ack(blk_ack),
    .blk_rdata(blk_rdata));
  hio_blk_model i_blk (.core_clk(core_clk), .slow(slow), .blk(blk), .blk_ack(blk_ack),
    .blk_rdata(blk_rdata), .wr_count(wr_count));

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (phys_wr.en === 1'b1) begin
      io_out[phys_wr.addr] <= phys_wr.val;
      pulse_n <= pulse_n + 1;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk16
  task automatic put_word(input logic [15:0] w);
    int t;
    t = 0;
    @(negedge core_clk);
    in_valid = 1'b1;
    in_data = w;
    do begin @(posedge core_clk); t++; end while (in_ready !== 1'b1 && t < 300);
    if (t >= 300) chk16(16'h0, 16'h1, "command word not taken");
  endtask : put_word
  task automatic get_word(output logic [15:0] w);
    int t;
    t = 0;
    @(negedge core_clk);
    if (stall > 0) begin
      out_ready = 1'b0;
      repeat (stall) @(negedge core_clk);
    end
    out_ready = 1'b1;
    do begin @(posedge core_clk); t++; end while (out_valid !== 1'b1 && t < 300);
    if (t >= 300) chk16(16'h0, 16'h1, "answer word missing");
    w = out_data;
  endtask : get_word
  task automatic run_cmd(input logic [7:0] op, input int nb, input logic [0:3][15:0] b);
    // host talks and listens at once: scattered reads take each address after the header
    fork
      begin
        put_word({8'h0, op});
        put_word(16'(2 * nb));
        for (int i = 0; i < nb; i++) put_word(b[i]);
        @(negedge core_clk);
        in_valid = 1'b0;
      end
      begin
        get_word(rop);
        get_word(rlen);
        rq = {};
        for (int i = 0; i < rlen / 2; i++) begin get_word(x); rq.push_back(x); end
      end
    join
  endtask : run_cmd
  task automatic scan(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    scan_we = 1'b1;
    scan_addr = a;
    scan_data = d;
    @(negedge core_clk);
    scan_we = 1'b0;
  endtask : scan

  initial begin
    #400000;
    chk16(16'h0, 16'h1, "watchdog expired");
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    scan(8'h2, 16'h00f0);
    scan(8'h4, 16'h0000);
    // pull and push rows only address the block-transfer model
    foreach (rows[i]) begin
      @(negedge core_clk);
      write_protect = rows[i].wp;
      mode = hio_pkg::hio_mode_t'(rows[i].md);
      run_cmd(rows[i].op, rows[i].nb, rows[i].b);
      chk16(rop, {8'h0, rows[i].eop}, "answer opcode");
      chk16(rlen, rows[i].elen, "answer length");
      if (rows[i].elen != 0) chk16(rq[0], rows[i].ed0, "first word");
      if (rows[i].elen != 0) chk16(rq[$], rows[i].el, "last word");
    end
    chk16(16'(pulse_n), 16'd38, "output pulses");
    chk16({10'h0, io_out[37], io_out[36], io_out[35], io_out[34], io_out[41], io_out[40]},
      16'h2a, "real outputs");
    chk16({13'h0, io_out[79], io_out[65], io_out[64]}, 16'h5, "block outputs");
    chk16(i_blk.mem[20], 16'h1111, "pushed word 0");
    chk16(i_blk.mem[21], 16'h2222, "pushed word 1");
    chk16(16'(wr_count), 16'd2, "push count");
    // slow module and a stalling host together
    @(negedge core_clk);
    slow = 1'b1;
    stall = 3;
    mode = hio_pkg::MODE_RUN_PROGRAM;
    run_cmd(8'h1c, 2, '{16'h3, 16'h5, 16'h0, 16'h0});
    chk16(rq[1], 16'ha5c5, "slow pull middle");
    chk16(16'(rq.size()), 16'd3, "slow pull size");
    stall = 0;
    // reset while a write command is half sent
    put_word({8'h0, hio_pkg::OP_WR_REG});
    put_word(16'h6);
    put_word(16'h1);
    @(negedge core_clk);
    in_valid = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    chk16({14'h0, in_ready, out_valid}, 16'h2, "idle after reset");
    run_cmd(8'h04, 2, '{16'h1, 16'h1000, 16'h0, 16'h0});
    chk16(rq[0], 16'hffff, "register kept");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
